// *** include/ccs_pkg.sv ***
`default_nettype none
package ccs_pkg;
  // opcode fields of the 16-bit instruction word
  localparam logic [5:0] OP_COMPLEMENT = 6'h07;  // 0001 11da
  localparam logic [6:0] OP_CMP_SKIP = 7'h31;    // 0110 001a
  localparam int OP6_LSB = 10;
  localparam int OP7_LSB = 9;
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT = 8;
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;    // indexed mode for f <= 95
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;   // access bank low/high split
  localparam logic [3:0] SFR_BANK = 4'hF;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int INSN_W = 16;
  // phases of one instruction cycle
  typedef enum logic [1:0] {
    CCS_Q1 = 2'b00,
    CCS_Q2 = 2'b01,
    CCS_Q3 = 2'b10,
    CCS_Q4 = 2'b11
  } ccs_phase_t;
  // skip sequencing states
  typedef enum logic [1:0] {
    CCS_RUN = 2'b00,
    CCS_NOP1 = 2'b01,
    CCS_NOP2 = 2'b10
  } ccs_skip_t;
endpackage
`default_nettype wire

// *** rtl/ccs_addr_gen.sv ***
`default_nettype none
// forms the 12-bit data address of a file operand, result held in a register
module ccs_addr_gen (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] file_i,
  input wire logic access_sel_i,
  input wire logic ext_set_en_i,
  input wire logic [3:0] bank_select_pointer_i,
  input wire logic [11:0] index_base_i,
  output logic [11:0] addr_o
);
  typedef struct packed {
    logic [11:0] addr;
  } ccs_ag_state_t;
  ccs_ag_state_t st_ff, nxt_st;

  // access bank, banked or indexed literal offset
  always_comb begin
    nxt_st = st_ff;
    if (access_sel_i) begin
      nxt_st.addr = {bank_select_pointer_i, file_i};
    end else if (ext_set_en_i && file_i <= ccs_pkg::INDEX_LIMIT) begin
      nxt_st.addr = index_base_i + {4'h0, file_i};
    end else if (file_i < ccs_pkg::ACCESS_SPLIT) begin
      nxt_st.addr = {4'h0, file_i};
    end else begin
      nxt_st.addr = {ccs_pkg::SFR_BANK, file_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign addr_o = st_ff.addr;
endmodule
`default_nettype wire

// *** rtl/ccs_exec.sv ***
`default_nettype none
// Functional notes
// - complement op writes inverted data byte
// - dest bit: 0 accumulator, 1 file byte
// - access bit: 0 access bank, 1 pointer
// - indexed offset when extended and f<=95
// - compare by unsigned subtract, operands unchanged
// - equal: discard next, one nop cycle
// - two-word next instruction: second nop
module ccs_exec (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic insn_valid_i,
  input wire logic [15:0] insn_i,
  input wire logic next_two_word_i,
  input wire logic ext_set_en_i,
  input wire logic [3:0] bank_select_pointer_i,
  input wire logic [11:0] index_base_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] rd_data_i,
  output logic [11:0] addr_o,
  output logic rd_en_o,
  output logic wr_en_o,
  output logic [7:0] wr_data_o,
  output logic acc_we_o,
  output logic [7:0] acc_data_o,
  output logic flag_we_o,
  output logic neg_o,
  output logic zero_o,
  output logic discard_o,
  output logic busy_o
);
  typedef struct packed {
    ccs_pkg::ccs_phase_t phase;
    ccs_pkg::ccs_skip_t skip;
    logic is_comp;
    logic is_cmp;
    logic dest;
    logic two_word;
    logic rd_en;
    logic wr_en;
    logic [7:0] wr_data;
    logic acc_we;
    logic [7:0] acc_data;
    logic flag_we;
    logic neg;
    logic zero;
    logic discard;
    logic busy;
  } ccs_state_t;
  ccs_state_t st_ff, nxt_st;
  logic [8:0] diff;
  logic [7:0] inv;
  logic [7:0] file_sel;
  logic op_comp;
  logic op_cmp;

  assign file_sel = insn_i[7:0];
  assign op_comp = insn_i[15:ccs_pkg::OP6_LSB] == ccs_pkg::OP_COMPLEMENT;
  assign op_cmp = insn_i[15:ccs_pkg::OP7_LSB] == ccs_pkg::OP_CMP_SKIP;

  ccs_addr_gen u_addr (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .file_i(file_sel),
    .access_sel_i(insn_i[ccs_pkg::ACC_BIT]),
    .ext_set_en_i(ext_set_en_i),
    .bank_select_pointer_i(bank_select_pointer_i),
    .index_base_i(index_base_i),
    .addr_o(addr_o)
  );

  // unsigned subtraction, only equality is used; no operand is written
  assign diff = {1'b0, rd_data_i} - {1'b0, acc_i};
  assign inv = ~rd_data_i;

  // four-phase sequencer: decode Q1, read Q2, process Q3, write Q4
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr_en = 1'b0;
    nxt_st.acc_we = 1'b0;
    nxt_st.flag_we = 1'b0;
    nxt_st.rd_en = 1'b0;
    case (st_ff.phase)
      ccs_pkg::CCS_Q1: begin
        nxt_st.phase = ccs_pkg::CCS_Q2;
        nxt_st.is_comp = 1'b0;
        nxt_st.is_cmp = 1'b0;
        // decode only when not flushing a skipped word
        if (st_ff.skip == ccs_pkg::CCS_RUN && insn_valid_i) begin
          nxt_st.is_comp = op_comp;
          nxt_st.is_cmp = op_cmp;
          nxt_st.dest = insn_i[ccs_pkg::DEST_BIT];
          nxt_st.two_word = next_two_word_i;
          nxt_st.rd_en = op_comp | op_cmp;
        end
      end
      ccs_pkg::CCS_Q2: begin
        nxt_st.phase = ccs_pkg::CCS_Q3;
      end
      ccs_pkg::CCS_Q3: begin
        nxt_st.phase = ccs_pkg::CCS_Q4;
        if (st_ff.is_comp) begin
          // result goes to one destination only
          nxt_st.wr_en = st_ff.dest;
          nxt_st.acc_we = ~st_ff.dest;
          nxt_st.wr_data = inv;
          nxt_st.acc_data = inv;
          nxt_st.flag_we = 1'b1;
          nxt_st.neg = inv[7];
          nxt_st.zero = inv == 8'h00;
        end
      end
      ccs_pkg::CCS_Q4: begin
        nxt_st.phase = ccs_pkg::CCS_Q1;
        case (st_ff.skip)
          ccs_pkg::CCS_RUN: begin
            if (st_ff.is_cmp && diff == 9'h000) begin
              nxt_st.skip = ccs_pkg::CCS_NOP1;
            end
          end
          ccs_pkg::CCS_NOP1: begin
            // second flush only when the dropped word has an operand word
            nxt_st.skip = st_ff.two_word ? ccs_pkg::CCS_NOP2 : ccs_pkg::CCS_RUN;
          end
          default: begin
            nxt_st.skip = ccs_pkg::CCS_RUN;
          end
        endcase
        nxt_st.is_comp = 1'b0;
        nxt_st.is_cmp = 1'b0;
      end
      default: begin
        nxt_st.phase = ccs_pkg::CCS_Q1;
      end
    endcase
    nxt_st.discard = nxt_st.skip != ccs_pkg::CCS_RUN;
    nxt_st.busy = nxt_st.is_comp | nxt_st.is_cmp | nxt_st.discard;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_en_o = st_ff.rd_en;
  assign wr_en_o = st_ff.wr_en;
  assign wr_data_o = st_ff.wr_data;
  assign acc_we_o = st_ff.acc_we;
  assign acc_data_o = st_ff.acc_data;
  assign flag_we_o = st_ff.flag_we;
  assign neg_o = st_ff.neg;
  assign zero_o = st_ff.zero;
  assign discard_o = st_ff.discard;
  assign busy_o = st_ff.busy;

  // compare never writes anything
  a_cmp_no_write: assert property (@(posedge clk_i) disable iff (reset_i)
    st_ff.is_cmp |-> !nxt_st.wr_en && !nxt_st.acc_we && !nxt_st.flag_we)
    else $error("compare wrote a destination");
  a_comp_dest: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_en_o |-> !acc_we_o && wr_data_o == ~$past(rd_data_i))
    else $error("complement routed wrong");
  a_comp_flags: assert property (@(posedge clk_i) disable iff (reset_i)
    (acc_we_o || wr_en_o) |-> flag_we_o && zero_o == (acc_data_o == 8'h00))
    else $error("complement flags wrong");
  a_skip_one: assert property (@(posedge clk_i) disable iff (reset_i)
    ($rose(discard_o) && !st_ff.two_word) |-> discard_o [*4] ##1 !discard_o)
    else $error("single skip length wrong");
  a_skip_two: assert property (@(posedge clk_i) disable iff (reset_i)
    ($rose(discard_o) && st_ff.two_word) |-> discard_o [*8] ##1 !discard_o)
    else $error("double skip length wrong");
  a_skip_cause: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(discard_o) |-> $past(st_ff.is_cmp) && $past(diff) == 9'h000)
    else $error("skip without equality");
  a_addr_bank: assert property (@(posedge clk_i) disable iff (reset_i)
    insn_i[ccs_pkg::ACC_BIT] ##1 $stable(insn_i)
      |-> addr_o == {$past(bank_select_pointer_i), $past(insn_i[7:0])})
    else $error("banked address wrong");
  a_comp_one_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
    (st_ff.phase == ccs_pkg::CCS_Q3 && st_ff.is_comp) |=> (wr_en_o || acc_we_o))
    else $error("complement did not finish in cycle");
  // indexed literal offset: base plus file operand, one clock later
  a_index_addr: assert property (@(posedge clk_i) disable iff (reset_i)
    (!insn_i[ccs_pkg::ACC_BIT] && ext_set_en_i && insn_i[7:0] <= ccs_pkg::INDEX_LIMIT)
      |=> addr_o == $past(index_base_i) + {4'h0, $past(insn_i[7:0])})
    else $error("indexed address wrong");
  // a word offered during a flush must never start a data read
  a_skip_drop: assert property (@(posedge clk_i) disable iff (reset_i)
    discard_o |=> !rd_en_o)
    else $error("skipped word was decoded");
  c_skip_one: cover property (@(posedge clk_i) $rose(discard_o) && !st_ff.two_word);
  c_skip_two: cover property (@(posedge clk_i) $rose(discard_o) && st_ff.two_word);
  c_comp_acc: cover property (@(posedge clk_i) acc_we_o);
  c_comp_file: cover property (@(posedge clk_i) wr_en_o);
endmodule
`default_nettype wire

// *** verification/ccs_mem_model.sv ***
`default_nettype none
// data memory on the far side of the core
module ccs_mem_model (
  input wire logic clk_i,
  input wire logic [11:0] addr_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [4096];
  logic hold_ff = 1'b0;
  initial rd_data_o = 8'h00;
  // data stand two edges, then invert so a late sample cannot pass
  always @(posedge clk_i) begin
    hold_ff <= rd_en_i;
    if (rd_en_i) rd_data_o <= mem[addr_i];
    else if (!hold_ff) rd_data_o <= ~rd_data_o;
    if (wr_en_i) mem[addr_i] <= wr_data_i;
  end
endmodule
`default_nettype wire

// *** verification/complement_compare_skip_exec_tb.sv ***
`default_nettype none
module complement_compare_skip_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic insn_valid_i = 1'b0;
  logic [15:0] insn_i = 16'h0000;
  logic next_two_word_i = 1'b0;
  logic ext_set_en_i = 1'b0;
  logic [7:0] acc_i = 8'h00;
  logic [7:0] rd_data_i, wr_data_o, acc_data_o, acc_seen;
  logic [11:0] addr_o;
  logic rd_en_o, wr_en_o, acc_we_o, flag_we_o, neg_o, zero_o, discard_o, busy_o;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [3:0] bsp = 4'h3;
  logic [11:0] base = 12'h200;
  int wr_n, acc_n, flag_n, disc_n, busy_n;
  always #10 clk_i = ~clk_i;
  ccs_exec dut_u (.clk_i(clk_i), .reset_i(reset_i), .insn_valid_i(insn_valid_i),
    .insn_i(insn_i), .next_two_word_i(next_two_word_i), .ext_set_en_i(ext_set_en_i),
    .bank_select_pointer_i(bsp), .index_base_i(base), .acc_i(acc_i),
    .rd_data_i(rd_data_i), .addr_o(addr_o), .rd_en_o(rd_en_o), .wr_en_o(wr_en_o),
    .wr_data_o(wr_data_o), .acc_we_o(acc_we_o), .acc_data_o(acc_data_o),
    .flag_we_o(flag_we_o), .neg_o(neg_o), .zero_o(zero_o), .discard_o(discard_o),
    .busy_o(busy_o));
  ccs_mem_model mem_u (.clk_i(clk_i), .addr_i(addr_o), .rd_en_i(rd_en_o),
    .wr_en_i(wr_en_o), .wr_data_i(wr_data_o), .rd_data_o(rd_data_i));
  // tally outputs at the falling edge, clear of the launching edge, so counts need no alignment
  always @(negedge clk_i) begin
    cycles++;
    if (wr_en_o) wr_n++;
    if (acc_we_o) acc_n++;
    if (acc_we_o) acc_seen = acc_data_o;
    if (flag_we_o) flag_n++;
    if (discard_o) disc_n++;
    if (busy_o) busy_n++;
    // the whole run needs about 140 clocks
    if (cycles == 400) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // presents one word at a Q1 edge and keeps the four-clock cadence
  task automatic run(input logic [15:0] w, input logic tw, input int blk);
    insn_i <= w;
    next_two_word_i <= tw;
    insn_valid_i <= 1'b1;
    @(posedge clk_i);
    insn_valid_i <= 1'b0;
    repeat (4 * blk - 1) @(posedge clk_i);
  endtask
  task automatic complement_register_op(input logic a, input logic d, input logic [7:0] f, input logic ext,
      input logic [11:0] ad, input logic [7:0] v);
    mem_u.mem[ad] = v;
    ext_set_en_i <= ext;
    acc_i <= 8'h3C;
    wr_n = 0;
    acc_n = 0;
    flag_n = 0;
    busy_n = 0;
    run({ccs_pkg::OP_COMPLEMENT, d, a, f}, 1'b0, 2);
    // concatenation keeps the inversion at byte width
    check(16'(mem_u.mem[ad]), {8'h00, d ? ~v : v});
    check(16'(wr_n * 2 + acc_n), d ? 16'h0002 : 16'h0001);
    if (!d) check(16'(acc_seen), {8'h00, ~v});
    check(16'(flag_n), 16'h0001);
    check({14'h0000, neg_o, zero_o}, {14'h0000, ~v[7], v == 8'hFF});
    check(16'(busy_n), 16'h0003);
    $display("complement test done");
  endtask
  task automatic cmp(input logic a, input logic [11:0] ad, input logic [7:0] v,
      input logic [7:0] w, input logic tw, input int n);
    mem_u.mem[ad] = v;
    ext_set_en_i <= 1'b1;
    acc_i <= w;
    wr_n = 0;
    acc_n = 0;
    flag_n = 0;
    disc_n = 0;
    busy_n = 0;
    run({ccs_pkg::OP_CMP_SKIP, a, 8'h44}, tw, 4);
    check(16'(disc_n), 16'(n));
    check(16'(wr_n + acc_n + flag_n), 16'h0000);
    check(16'(mem_u.mem[ad]), {8'h00, v});
    // busy covers read to write (Q2 to Q4), then every flushed clock
    check(16'(busy_n), 16'(3 + n));
    $display("compare test done");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    complement_register_op(1'b1, 1'b1, 8'h21, 1'b0, 12'h321, 8'h13);
    complement_register_op(1'b0, 1'b0, 8'h10, 1'b0, 12'h010, 8'hFF);
    complement_register_op(1'b0, 1'b1, 8'h80, 1'b0, 12'hF80, 8'h80);
    complement_register_op(1'b0, 1'b1, 8'h5F, 1'b1, 12'h25F, 8'h6A);
    complement_register_op(1'b0, 1'b1, 8'h60, 1'b1, 12'hF60, 8'h01);
    // another pointer value so a fixed bank cannot pass
    bsp <= 4'h5;
    complement_register_op(1'b1, 1'b0, 8'h5F, 1'b1, 12'h55F, 8'h00);
    bsp <= 4'h3;
    cmp(1'b1, 12'h344, 8'h5A, 8'h5A, 1'b0, 4);
    cmp(1'b0, 12'h244, 8'h5A, 8'h5A, 1'b1, 8);
    cmp(1'b1, 12'h344, 8'h5B, 8'h5A, 1'b0, 0);
    cmp(1'b1, 12'h344, 8'h00, 8'hFF, 1'b1, 0);
    // a word offered while the skip runs must be dropped
    mem_u.mem[12'h344] = 8'h11;
    acc_i <= 8'h11;
    wr_n = 0;
    run({ccs_pkg::OP_CMP_SKIP, 1'b1, 8'h44}, 1'b0, 1);
    run({ccs_pkg::OP_COMPLEMENT, 1'b1, 1'b1, 8'h44}, 1'b0, 3);
    check(16'(mem_u.mem[12'h344]), 16'h0011);
    check(16'(wr_n), 16'h0000);
    $display("discard test done");
    complete_run();
  end
endmodule
`default_nettype wire
